// ### verilog/pfsc_defs.svh
`ifndef PFSC_DEFS_SVH
`define PFSC_DEFS_SVH
// Timing
`define PFSC_CLK_PERIOD_NS 8
`define PFSC_NS_PER_MS 1000000
`define PFSC_CYC_PER_MS (`PFSC_NS_PER_MS / `PFSC_CLK_PERIOD_NS)
`define PFSC_PG_DELAY_MS 4
`define PFSC_RETRY_MS 70
`define PFSC_START_DELAY_MS 5
`define PFSC_RAMP_MS 5
// Register word offsets
`define PFSC_REG_CTRL 8'h00
`define PFSC_REG_UV_LIM 8'h01
`define PFSC_REG_OV_LIM 8'h02
`define PFSC_REG_OC_LIM 8'h03
`define PFSC_REG_OT_LIM 8'h04
`define PFSC_REG_ILV 8'h05
`define PFSC_REG_STATUS 8'h06
`define PFSC_REG_VOUT_CMD 8'h07
`define PFSC_REG_READ_VIN 8'h08
`define PFSC_REG_READ_VOUT 8'h09
`define PFSC_REG_READ_IOUT 8'h0A
`define PFSC_REG_READ_TEMP 8'h0B
`define PFSC_REG_READ_DUTY 8'h0C
`define PFSC_REG_READ_FREQ 8'h0D
`define PFSC_REG_READ_VMON 8'h0E
`define PFSC_REG_STRAP 8'h0F
`define PFSC_REG_STATE 8'h10
// Field positions
`define PFSC_CTRL_ON 0
`define PFSC_ILV_OVR 4
`define PFSC_FLT_UV 0
`define PFSC_FLT_OV 1
`define PFSC_FLT_OC 2
`define PFSC_FLT_OT 3
// Reset values, voltages in 10 mV steps, temperature in degrees C
`define PFSC_CTRL_RST 1'b1
`define PFSC_OT_RST 12'h073
`define PFSC_VOUT_RST 12'h064
`define PFSC_OC_RST 12'h0F0
// Undervoltage limits
`define PFSC_UV_MIN 12'h1A2
`define PFSC_UV_MAX 12'h640
`define PFSC_UV_4V20 12'h1A4
`define PFSC_UV_4V50 12'h1C2
`define PFSC_UV_4V59 12'h1CB
`define PFSC_UV_5V06 12'h1FA
`define PFSC_UV_5V57 12'h22D
`define PFSC_UV_6V13 12'h265
`define PFSC_UV_6V75 12'h2A3
`define PFSC_UV_7V42 12'h2E6
`define PFSC_UV_8V18 12'h332
`define PFSC_UV_10V8 12'h438
// Address strap
`define PFSC_ADDR_BASE 7'h19
`define PFSC_GRP1_IDX 6'h11
`define PFSC_ADDR_LAST_IDX 6'h20
// Overvoltage default 115 percent of target
`define PFSC_OV_NUM 115
`define PFSC_OV_DEN 100
`endif

// ### verilog/pfsc_pkg.sv
package pfsc_pkg;
  typedef enum logic [2:0] {
    PFSC_OFF = 3'b000,
    PFSC_DELAY = 3'b001,
    PFSC_RAMP = 3'b010,
    PFSC_ON = 3'b011,
    PFSC_RETRY = 3'b100
  } pfsc_fsm_t;

  // Telemetry words from the on-chip converter, same clock
  typedef struct packed {
    logic [11:0] vin;
    logic [11:0] vsense;
    logic [11:0] iout;
    logic [11:0] ipeak;
    logic [11:0] temp;
    logic [11:0] duty;
    logic [11:0] freq;
    logic [11:0] vmon;
  } pfsc_tlm_t;

  // Strap resistor codes from the strap converter, same clock
  typedef struct packed {
    logic [4:0] uv_code;
    logic [5:0] addr_code;
  } pfsc_strap_t;

  typedef struct packed {
    pfsc_fsm_t fsm;
    logic [23:0] cnt;
    logic [23:0] pg_cnt;
    logic pg;
    logic drv;
    logic strap_done;
    logic [6:0] addr;
    logic grp;
    logic on;
    logic [11:0] uv_lim;
    logic [11:0] ov_lim;
    logic ov_ovr;
    logic [11:0] oc_lim;
    logic [11:0] ot_lim;
    logic [11:0] vout_cmd;
    logic [4:0] ilv;
    logic [3:0] phase;
    logic [3:0] flt;
    logic [11:0] pre;
    logic pre_hi;
    logic [11:0] vref;
    logic [15:0] rdata;
  } pfsc_state_t;
endpackage

// ### verilog/pfsc_core.sv
// Summary of operation
// - Undervoltage limit settable 4.2V to 10.8V by strap, 4.18V to 16V by register.
// - Undervoltage strap decode: open 4.2V, low straps 4.5V, high 10.8V.
// - Input at undervoltage limit drops the drivers at once.
// - After undervoltage shutdown stay off until the fault flag is cleared.
// - Address strap decodes to 19h..29h, then 19h..28h.
// - Same strap picks voltage group: up to 46.4k group 0, else 1.
// - Overvoltage limit defaults to 115 percent of target, reprogrammable.
// - Sense above overvoltage limit shuts down, no retry.
// - Output voltage sampled before the ramp starts.
// - Prebias below target: reference starts at prebias, ramps to target.
// - Below-target ramp lasts the configured ramp time, whatever prebias.
// - Prebias above target: drivers run at the prebias voltage.
// - Above target: after ramp time, power good, then ramp down.
// - Prebias above overvoltage limit: no turn-on, overvoltage fault.
// - Peak current limit from input, frequency, output; average by register.
// - Overcurrent shuts down and retries every 70ms.
// - Over-temperature limit resets to 115C, reprogrammable.
// - Temperature above limit shuts down, no retry.
// - Phase offset is address low nibble times 22.5 degrees.
// - Interleave register overrides the address-derived phase.
// - Telemetry readable: vin, vout, iout, temp, duty, freq, monitor.
// - Power good waits 4ms after its conditions hold.
`timescale 1ns/100ps
`include "pfsc_defs.svh"

module pfsc_core
  import pfsc_pkg::*;
#(
  parameter int DELAY_CYC = `PFSC_START_DELAY_MS * `PFSC_CYC_PER_MS,
  parameter int RAMP_CYC = `PFSC_RAMP_MS * `PFSC_CYC_PER_MS,
  parameter int PG_DELAY_CYC = `PFSC_PG_DELAY_MS * `PFSC_CYC_PER_MS,
  parameter int RETRY_CYC = `PFSC_RETRY_MS * `PFSC_CYC_PER_MS,
  parameter int RIPPLE_K = 256
) (
  input wire logic core_clk_in, // 125 MHz core clock
  input wire logic reset_in, // Synchronous, active high
  input wire logic ce_in, // Freezes all state when low
  input wire pfsc_strap_t strap_in, // Strap resistor codes
  input wire pfsc_tlm_t tlm_in, // Telemetry words
  input wire logic [7:0] addr_in, // Register word offset
  input wire logic [15:0] wdata_in, // Register write data
  input wire logic wr_in, // Write strobe
  input wire logic rd_in, // Read strobe
  output logic [15:0] rdata_out, // Read data, cycle after strobe
  output logic drivers_en_out, // Both power drivers enabled
  output logic [11:0] vref_out, // Internal target voltage
  output logic power_good_out, // Power good, active high
  output logic [6:0] bus_addr_out, // Decoded bus address
  output logic voltage_set_group_out, // Decoded voltage-set group
  output logic [3:0] phase_offset_out, // Phase in 22.5 degree steps
  output logic [3:0] fault_flags_out // Sticky uv, ov, oc, ot
);
  localparam pfsc_state_t ST_RST = '{fsm: PFSC_OFF, on: `PFSC_CTRL_RST,
    ot_lim: `PFSC_OT_RST, vout_cmd: `PFSC_VOUT_RST,
    oc_lim: `PFSC_OC_RST, uv_lim: `PFSC_UV_4V50, default: '0};

  pfsc_state_t st_q;
  pfsc_state_t st_d;
  logic [11:0] ov_dflt;
  logic [11:0] ov_eff;
  logic [11:0] pk_lim;
  logic [31:0] rip_num;
  logic [31:0] rip_den;
  logic [31:0] rip;
  logic uv_now;
  logic ov_now;
  logic oc_now;
  logic ot_now;
  logic trip_now;

  // Strap code 0 open, 1 rail, 2 ground, 3.. ascending resistors
  function automatic logic [11:0] uv_decode(input logic [4:0] code);
    case (code)
      5'h00: uv_decode = `PFSC_UV_4V20;
      5'h0B: uv_decode = `PFSC_UV_4V20;
      5'h0C: uv_decode = `PFSC_UV_4V59;
      5'h0D: uv_decode = `PFSC_UV_5V06;
      5'h0E: uv_decode = `PFSC_UV_5V57;
      5'h0F: uv_decode = `PFSC_UV_6V13;
      5'h10: uv_decode = `PFSC_UV_6V75;
      5'h11: uv_decode = `PFSC_UV_7V42;
      5'h12: uv_decode = `PFSC_UV_8V18;
      default: uv_decode = (code > 5'h12) ? `PFSC_UV_10V8 : `PFSC_UV_4V50;
    endcase
  endfunction

  // Index in table order; out-of-range codes act as the last entry (index 20h)
  function automatic logic [7:0] addr_decode(input logic [5:0] code);
    logic [5:0] idx;
    idx = (code > `PFSC_ADDR_LAST_IDX) ? `PFSC_ADDR_LAST_IDX : code;
    if (idx >= `PFSC_GRP1_IDX) begin
      addr_decode = {1'b1, `PFSC_ADDR_BASE +
        7'(idx - `PFSC_GRP1_IDX)};
    end else begin
      addr_decode = {1'b0, `PFSC_ADDR_BASE + 7'(idx)};
    end
  endfunction

  function automatic logic [11:0] uv_clamp(input logic [11:0] v);
    if (v < `PFSC_UV_MIN) begin
      uv_clamp = `PFSC_UV_MIN;
    end else if (v > `PFSC_UV_MAX) begin
      uv_clamp = `PFSC_UV_MAX;
    end else begin
      uv_clamp = v;
    end
  endfunction

  assign ov_dflt = 12'((32'(st_q.vout_cmd) * `PFSC_OV_NUM) / `PFSC_OV_DEN);
  assign ov_eff = st_q.ov_ovr ? st_q.ov_lim : ov_dflt;

  // ripple from live vin, switching frequency and commanded vout
  always_comb begin
    rip_num = '0;
    if (tlm_in.vin > st_q.vout_cmd) begin
      rip_num = 32'(tlm_in.vin - st_q.vout_cmd) * 32'(st_q.vout_cmd) *
        32'(RIPPLE_K);
    end
    rip_den = 32'(tlm_in.vin) * 32'(tlm_in.freq);
    rip = (rip_den == '0) ? '0 : rip_num / rip_den;
  end
  assign pk_lim = 12'(32'(st_q.oc_lim) + (rip >> 1));

  assign uv_now = tlm_in.vin <= st_q.uv_lim;
  assign ov_now = tlm_in.vsense > ov_eff;
  assign ot_now = tlm_in.temp > st_q.ot_lim;
  assign oc_now = (tlm_in.iout > st_q.oc_lim) || (tlm_in.ipeak > pk_lim);
  assign trip_now = uv_now || ov_now || ot_now || oc_now;

  always_comb begin
    logic [3:0] flt_set;
    logic [3:0] flt_clr;
    logic running;
    st_d = st_q;
    flt_set = '0;
    flt_clr = '0;
    running = st_q.fsm inside {PFSC_DELAY, PFSC_RAMP, PFSC_ON};
    if (!st_q.strap_done) begin
      st_d.strap_done = 1'b1;
      st_d.uv_lim = uv_decode(strap_in.uv_code);
      {st_d.grp, st_d.addr} = addr_decode(strap_in.addr_code);
    end
    if (wr_in) begin
      case (addr_in)
        `PFSC_REG_CTRL: st_d.on = wdata_in[`PFSC_CTRL_ON];
        `PFSC_REG_UV_LIM: st_d.uv_lim = uv_clamp(wdata_in[11:0]);
        `PFSC_REG_OV_LIM: begin
          st_d.ov_lim = wdata_in[11:0];
          st_d.ov_ovr = 1'b1;
        end
        `PFSC_REG_OC_LIM: st_d.oc_lim = wdata_in[11:0];
        `PFSC_REG_OT_LIM: st_d.ot_lim = wdata_in[11:0];
        `PFSC_REG_ILV: st_d.ilv = wdata_in[4:0];
        `PFSC_REG_STATUS: flt_clr = wdata_in[3:0];
        `PFSC_REG_VOUT_CMD: st_d.vout_cmd = wdata_in[11:0];
        default: ;
      endcase
    end
    st_d.phase = st_q.ilv[`PFSC_ILV_OVR] ? st_q.ilv[3:0] : st_q.addr[3:0];
    st_d.pg_cnt = '0;
    st_d.pg = 1'b0;
    unique case (st_q.fsm)
      PFSC_OFF: begin
        st_d.drv = 1'b0;
        // restart only once latched uv, ov and ot faults are cleared
        if (st_q.on && st_q.strap_done && !uv_now &&
            !st_q.flt[`PFSC_FLT_UV] && !st_q.flt[`PFSC_FLT_OV] &&
            !st_q.flt[`PFSC_FLT_OT]) begin
          st_d.fsm = PFSC_DELAY;
          st_d.cnt = '0;
        end
      end
      PFSC_DELAY: begin
        // keep sampling until the delay ends
        st_d.pre = tlm_in.vsense;
        st_d.cnt = st_q.cnt + 24'h000001;
        if (st_q.cnt == 24'(DELAY_CYC - 1)) begin
          st_d.cnt = '0;
          if (tlm_in.vsense > ov_eff) begin
            flt_set[`PFSC_FLT_OV] = 1'b1;
            st_d.fsm = PFSC_OFF;
          end else begin
            st_d.pre_hi = tlm_in.vsense > st_q.vout_cmd;
            st_d.vref = tlm_in.vsense;
            st_d.drv = 1'b1;
            st_d.fsm = PFSC_RAMP;
          end
        end
      end
      PFSC_RAMP: begin
        st_d.cnt = st_q.cnt + 24'h000001;
        // slope scaled so the ramp always spans RAMP_CYC
        if (!st_q.pre_hi && st_q.vout_cmd > st_q.pre) begin
          st_d.vref = st_q.pre + 12'((32'(st_q.vout_cmd - st_q.pre) *
            32'(st_d.cnt)) / RAMP_CYC);
        end
        if (st_q.cnt == 24'(RAMP_CYC - 1)) begin
          st_d.cnt = '0;
          st_d.fsm = PFSC_ON;
          if (!st_q.pre_hi) begin
            st_d.vref = st_q.vout_cmd;
          end
        end
      end
      PFSC_ON: begin
        st_d.pg = st_q.pg;
        st_d.pg_cnt = st_q.pg_cnt;
        if (st_q.pg_cnt == 24'(PG_DELAY_CYC - 1)) begin
          st_d.pg = 1'b1;
        end else begin
          st_d.pg_cnt = st_q.pg_cnt + 24'h000001;
        end
        // ramp down only after power good
        if (st_q.vref > st_q.vout_cmd) begin
          if (st_q.pg) begin
            st_d.vref = st_q.vref - 12'h001;
          end
        end else begin
          st_d.vref = st_q.vout_cmd;
        end
      end
      PFSC_RETRY: begin
        st_d.drv = 1'b0;
        st_d.cnt = st_q.cnt + 24'h000001;
        if (!st_q.on) begin
          st_d.fsm = PFSC_OFF;
        end else if (st_q.cnt == 24'(RETRY_CYC - 1)) begin
          st_d.cnt = '0;
          st_d.fsm = PFSC_DELAY;
        end
      end
      default: begin
        st_d.fsm = PFSC_OFF;
        st_d.drv = 1'b0;
      end
    endcase
    if (running) begin
      if (uv_now || ov_now || ot_now) begin
        flt_set[`PFSC_FLT_UV] = uv_now;
        flt_set[`PFSC_FLT_OV] = ov_now;
        flt_set[`PFSC_FLT_OT] = ot_now;
        st_d.fsm = PFSC_OFF;
        st_d.drv = 1'b0;
        st_d.pg = 1'b0;
      end else if (oc_now) begin
        flt_set[`PFSC_FLT_OC] = 1'b1;
        st_d.fsm = PFSC_RETRY;
        st_d.cnt = '0;
        st_d.drv = 1'b0;
        st_d.pg = 1'b0;
      end else if (!st_q.on) begin
        st_d.fsm = PFSC_OFF;
        st_d.drv = 1'b0;
        st_d.pg = 1'b0;
      end
    end
    // New faults win over a clear in the same cycle
    st_d.flt = (st_q.flt & ~flt_clr) | flt_set;
    st_d.rdata = '0;
    if (rd_in) begin
      case (addr_in)
        `PFSC_REG_CTRL: st_d.rdata = {15'h0000, st_q.on};
        `PFSC_REG_UV_LIM: st_d.rdata = {4'h0, st_q.uv_lim};
        `PFSC_REG_OV_LIM: st_d.rdata = {4'h0, ov_eff};
        `PFSC_REG_OC_LIM: st_d.rdata = {4'h0, st_q.oc_lim};
        `PFSC_REG_OT_LIM: st_d.rdata = {4'h0, st_q.ot_lim};
        `PFSC_REG_ILV: st_d.rdata = {11'h000, st_q.ilv};
        `PFSC_REG_STATUS: st_d.rdata = {12'h000, st_q.flt};
        `PFSC_REG_VOUT_CMD: st_d.rdata = {4'h0, st_q.vout_cmd};
        `PFSC_REG_READ_VIN: st_d.rdata = {4'h0, tlm_in.vin};
        `PFSC_REG_READ_VOUT: st_d.rdata = {4'h0, tlm_in.vsense};
        `PFSC_REG_READ_IOUT: st_d.rdata = {4'h0, tlm_in.iout};
        `PFSC_REG_READ_TEMP: st_d.rdata = {4'h0, tlm_in.temp};
        `PFSC_REG_READ_DUTY: st_d.rdata = {4'h0, tlm_in.duty};
        `PFSC_REG_READ_FREQ: st_d.rdata = {4'h0, tlm_in.freq};
        `PFSC_REG_READ_VMON: st_d.rdata = {4'h0, tlm_in.vmon};
        `PFSC_REG_STRAP: st_d.rdata = {8'h00, st_q.grp, st_q.addr};
        `PFSC_REG_STATE: st_d.rdata = {11'h000, st_q.pg, st_q.drv,
          st_q.fsm};
        default: st_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      st_q <= ST_RST;
    end else if (ce_in) begin
      st_q <= st_d;
    end
  end

  // combinational gate so a trip cuts drive in its own cycle
  assign drivers_en_out = st_q.drv && !trip_now;
  assign rdata_out = st_q.rdata;
  assign vref_out = st_q.vref;
  assign power_good_out = st_q.pg;
  assign bus_addr_out = st_q.addr;
  assign voltage_set_group_out = st_q.grp;
  assign phase_offset_out = st_q.phase;
  assign fault_flags_out = st_q.flt;

  // Checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);

  sequence s_delay_end;
    ce_in && st_q.fsm == PFSC_DELAY && st_q.cnt == 24'(DELAY_CYC - 1);
  endsequence
  sequence s_running;
    ce_in && st_q.fsm inside {PFSC_DELAY, PFSC_RAMP, PFSC_ON};
  endsequence

  uv_cutoff_a: assert property (
    uv_now |-> !drivers_en_out ##1 (!$past(ce_in) || !st_q.drv))
    else $error("drivers on at undervoltage");
  uv_hold_off_a: assert property (
    st_q.flt[`PFSC_FLT_UV] |-> !drivers_en_out && st_q.fsm != PFSC_DELAY)
    else $error("restart with undervoltage pending");
  ov_no_retry_a: assert property (
    s_running ##0 (ov_now && !wr_in) |=> st_q.fsm == PFSC_OFF
      && st_q.flt[`PFSC_FLT_OV] ##1 st_q.fsm != PFSC_RAMP)
    else $error("overvoltage did not latch off");
  prebias_ov_a: assert property (
    s_delay_end ##0 ov_now |=> st_q.fsm == PFSC_OFF && !st_q.drv)
    else $error("turn-on above overvoltage limit");
  prebias_start_a: assert property (
    s_delay_end ##0 !trip_now && st_q.on
      |=> st_q.fsm == PFSC_RAMP && st_q.vref == $past(tlm_in.vsense))
    else $error("ramp not started at prebias");
  ramp_end_a: assert property (
    ce_in && st_q.fsm == PFSC_RAMP && !st_q.pre_hi && !trip_now
      && st_q.on && st_q.cnt == 24'(RAMP_CYC - 1)
      |=> st_q.vref == $past(st_q.vout_cmd))
    else $error("ramp missed target at ramp end");
  pg_delay_a: assert property (
    $rose(power_good_out) |-> st_q.pg_cnt == 24'(PG_DELAY_CYC - 1))
    else $error("power good delay wrong");
  oc_retry_a: assert property (
    ce_in && st_q.fsm == PFSC_RETRY && st_q.on
      && st_q.cnt == 24'(RETRY_CYC - 1) |=> st_q.fsm == PFSC_DELAY)
    else $error("overcurrent retry not taken");
  ot_trip_a: assert property (
    s_running ##0 ot_now |=> !st_q.drv ##1 st_q.fsm == PFSC_OFF)
    else $error("over-temperature did not stay off");
  phase_map_a: assert property (
    ce_in && !st_q.ilv[`PFSC_ILV_OVR]
      |=> phase_offset_out == $past(bus_addr_out[3:0]))
    else $error("phase not from address nibble");
endmodule

// ### verification/pfsc_plant.sv
`timescale 1ns/100ps

module pfsc_plant
  import pfsc_pkg::*;
(
  input wire logic core_clk_in, // Shared switching clock
  input wire logic drivers_en_in, // Power drivers running
  input wire logic [11:0] vref_in, // Target from the block
  input wire logic [11:0] vin_in, // Input rail
  input wire logic [11:0] pre_in, // Prebias while undriven
  input wire logic [11:0] bump_in, // Excursion above target
  input wire logic [11:0] iout_in, // Load current
  input wire logic [11:0] temp_in, // Module temperature
  output pfsc_tlm_t tlm_out // Telemetry words
);
  logic [11:0] vout_q;

  // common clock
  // Registered so the trip path never loops back combinationally
  always_ff @(posedge core_clk_in) begin
    vout_q <= drivers_en_in ? vref_in + bump_in : pre_in;
  end

  assign tlm_out = '{vin: vin_in, vsense: vout_q, iout: iout_in,
    ipeak: iout_in, temp: temp_in, duty: 12'h02A, freq: 12'h1F4,
    vmon: vin_in >> 2};
endmodule

// ### verification/tb_pol_fault_and_strap_config.sv
`timescale 1ns/100ps
`define CHK(what, exp, got) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
      failures++; \
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); \
    end \
  end

module tb_pol_fault_and_strap_config;
  import pfsc_pkg::*;
  localparam int DLY = 20;
  localparam int RMP = 40;
  localparam int PGD = 30;
  localparam int RTY = 50;
  localparam int HOLD = DLY + RMP + RTY + 10;
  localparam logic [5:0] AC [5] = '{6'h00, 6'h10, 6'h11, 6'h20, 6'h1E};
  localparam logic [4:0] UC [5] = '{5'h00, 5'h01, 5'h1A, 5'h0B, 5'h0C};
  localparam logic [6:0] EA [5] = '{7'h19, 7'h29, 7'h19, 7'h28, 7'h26};
  localparam logic EG [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
  localparam logic [11:0] EU [5] = '{12'h1A4, 12'h1C2, 12'h438, 12'h1A4,
    12'h1CB};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  pfsc_strap_t strap = '0;
  logic [11:0] vin = 12'h100;
  logic [11:0] pre = 12'h032;
  logic [11:0] bump = 12'h000;
  logic [11:0] iout = 12'h010;
  logic [11:0] temp = 12'h019;
  pfsc_tlm_t tlm;
  logic [15:0] rdata;
  logic drv;
  logic [11:0] vref;
  logic pwr_good;
  logic [6:0] baddr;
  logic grp;
  logic [3:0] phase;
  logic [3:0] flags;
  int failures = 0;
  int checks_done = 0;

  always #4 clk = ~clk;

  pfsc_core #(.DELAY_CYC(DLY), .RAMP_CYC(RMP), .PG_DELAY_CYC(PGD),
    .RETRY_CYC(RTY), .RIPPLE_K(256)) dut (
    .core_clk_in(clk), .reset_in(rst), .ce_in(ce), .strap_in(strap),
    .tlm_in(tlm), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
    .rd_in(rd), .rdata_out(rdata), .drivers_en_out(drv),
    .vref_out(vref), .power_good_out(pwr_good), .bus_addr_out(baddr),
    .voltage_set_group_out(grp), .phase_offset_out(phase),
    .fault_flags_out(flags));

  pfsc_plant plant (.core_clk_in(clk), .drivers_en_in(drv),
    .vref_in(vref), .vin_in(vin), .pre_in(pre), .bump_in(bump),
    .iout_in(iout), .temp_in(temp), .tlm_out(tlm));

  task automatic close_out();
    if (failures == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic reset_dut();
    @(posedge clk);
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic chk_reg(input logic [7:0] a, input logic [15:0] e,
                         input string what);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(what, e, rdata)
  endtask

  // Bounded wait on drivers (0), power good (1) or target (2)
  task automatic wait_on(input int sel, input logic [11:0] v,
                         input int lim, output int n);
    logic [11:0] cur;
    n = 0;
    forever begin
      cur = sel == 0 ? 12'(drv) : sel == 1 ? 12'(pwr_good) : vref;
      if (cur === v || n >= lim)
        break;
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  task automatic run_up(input logic [11:0] p);
    int n;
    @(posedge clk);
    pre <= p;
    vin <= 12'h4B0;
    wr_reg(8'h06, 16'h000F);
    #1;
    wait_on(0, 12'h001, DLY + 20, n);
    `CHK("drivers on", 1'b1, drv) // start after delay
    `CHK("start target", p, vref) // prebias start
  endtask

  // Trip latency up to maxn cycles, then flag and optional hold
  task automatic expect_off(input int b, input int maxn, input int hold);
    int n;
    wait_on(0, 12'h000, 4, n);
    `CHK("trip time", 1'b1, n <= maxn) // immediate
    repeat (2) @(posedge clk);
    #1;
    `CHK("fault flag", 1'b1, flags[b]) // flag
    repeat (hold) @(posedge clk);
    #1;
    `CHK("stays off", 1'b0, drv) // no retry
  endtask

  initial begin
    int n;
    int n1;
    int n2;
    logic [11:0] tv [7];
    // lone module on this bus, so its address is unique
    for (int i = 0; i < 5; i++) begin
      strap <= '{uv_code: UC[i], addr_code: AC[i]};
      reset_dut();
      repeat (3) @(posedge clk);
      #1;
      `CHK("bus address", EA[i], baddr) // address table
      `CHK("group", EG[i], grp) // group split
      `CHK("phase", EA[i][3:0], phase) // address phase
      chk_reg(8'h01, {4'h0, EU[i]}, "uv limit"); // strap decode
      chk_reg(8'h0F, {8'h00, EG[i], EA[i]}, "strap word"); // readback
    end
    strap <= '{uv_code: 5'h03, addr_code: 6'h05};
    repeat (3) @(posedge clk);
    #1;
    `CHK("strap held", 7'h26, baddr) // decode once
    chk_reg(8'h04, 16'h0073, "ot reset"); // default limit
    chk_reg(8'h02, 16'h0073, "ov default"); // 115 percent
    chk_reg(8'h03, 16'h00F0, "oc reset"); // average limit
    wr_reg(8'h07, 16'h00C8);
    chk_reg(8'h02, 16'h00E6, "ov follows"); // tracks target
    wr_reg(8'h02, 16'h0080);
    chk_reg(8'h02, 16'h0080, "ov override"); // reprogram
    wr_reg(8'h02, 16'h0073);
    wr_reg(8'h07, 16'h0064);
    wr_reg(8'h04, 16'h0064);
    chk_reg(8'h04, 16'h0064, "ot write"); // reprogram
    wr_reg(8'h04, 16'h0073);
    @(posedge clk);
    ce <= 1'b0;
    wr_reg(8'h04, 16'h0050);
    @(posedge clk);
    ce <= 1'b1;
    chk_reg(8'h04, 16'h0073, "frozen write"); // write refused
    wr_reg(8'h01, 16'h0100);
    chk_reg(8'h01, 16'h01A2, "uv low clamp"); // lower bound
    wr_reg(8'h01, 16'h0700);
    chk_reg(8'h01, 16'h0640, "uv high clamp"); // upper bound
    wr_reg(8'h01, 16'h01CB);
    chk_reg(8'h01, 16'h01CB, "uv write"); // in range
    wr_reg(8'h05, 16'h0015);
    repeat (2) @(posedge clk);
    #1;
    `CHK("phase override", 4'h5, phase) // interleave
    wr_reg(8'h05, 16'h0000);
    repeat (2) @(posedge clk);
    #1;
    `CHK("phase restore", 4'h6, phase) // from address
    tv = '{12'h100, 12'h032, 12'h010, 12'h019, 12'h02A, 12'h1F4, 12'h040};
    for (int i = 0; i < 7; i++)
      chk_reg(8'h08 + 8'(i), {4'h0, tv[i]}, "telemetry"); // reads
    run_up(12'h032);
    wait_on(2, 12'h064, RMP + 10, n1);
    `CHK("ramp time", 1'b1, n1 >= RMP - 2 && n1 <= RMP + 1) // ramp
    `CHK("early good", 1'b0, pwr_good) // wait first
    wait_on(1, 12'h001, PGD + 10, n);
    `CHK("good delay", 1'b1, n >= PGD - 3 && n <= PGD + 2) // delay
    @(posedge clk);
    vin <= 12'h100;
    #1;
    expect_off(0, 0, HOLD); // input undervoltage
    @(posedge clk);
    vin <= 12'h4B0;
    repeat (DLY + RMP) @(posedge clk);
    #1;
    `CHK("uv latched", 1'b0, drv) // until cleared
    run_up(12'h000);
    wait_on(2, 12'h064, RMP + 10, n2);
    `CHK("same ramp", n1, n2) // any prebias
    @(posedge clk);
    bump <= 12'h100;
    #1;
    expect_off(1, 2, 0); // overvoltage
    bump <= 12'h000;
    expect_off(1, 0, HOLD); // no retry
    run_up(12'h032);
    @(posedge clk);
    temp <= 12'h080;
    #1;
    expect_off(3, 1, HOLD); // over temperature
    temp <= 12'h019;
    run_up(12'h032);
    @(posedge clk);
    iout <= 12'h100;
    #1;
    expect_off(2, 1, 0); // overcurrent
    iout <= 12'h010;
    wait_on(0, 12'h001, RTY + DLY + 20, n);
    `CHK("retry", 1'b1, n >= RTY + DLY - 6 && n <= RTY + DLY + 4)
    @(posedge clk);
    vin <= 12'h100;
    run_up(12'h06E);
    wait_on(1, 12'h001, RMP + PGD + 10, n);
    `CHK("high good", 1'b1, pwr_good) // good after ramp
    `CHK("high hold", 12'h06E, vref) // holds prebias
    wait_on(2, 12'h064, 20, n);
    `CHK("ramp down", 1'b1, n >= 9 && n <= 12) // down to target
    chk_reg(8'h10, 16'h001B, "state word"); // good and driving
    wr_reg(8'h00, 16'h0000);
    chk_reg(8'h10, 16'h0000, "off state"); // good drops when off
    wr_reg(8'h00, 16'h0001);
    @(posedge clk);
    vin <= 12'h100;
    @(posedge clk);
    vin <= 12'h4B0;
    wr_reg(8'h06, 16'h000F);
    // prebias crosses the limit just as the delay ends
    repeat (DLY - 1) @(posedge clk);
    pre <= 12'h0A0;
    #1;
    wait_on(0, 12'h001, DLY + 10, n);
    `CHK("no turn on", 1'b0, drv) // prebias over limit
    `CHK("ov declared", 1'b1, flags[1]) // fault
    close_out();
  end

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    close_out();
  end
endmodule
